/* terp_port.v */
// trigger event readout port: event capture on accept bits, busy flow control,
// bus readout of the event store and board registers, readout token handoff
// assumes all inputs are synchronous to i_core_clk and bus requests are one-cycle strobes
// Behaviour
// - the 32-bit address space only opens the event store for draining.
// - event store reads answer both single beats and block beats, two-edge mode included.
// - board control and status registers sit in the 24-bit address space.
// - block modifiers in the 24-bit space are refused; only single accesses work there.
// - in token readout modules answer two-edge beats in turn so one host sweep drains them all.
// - the grant arrives on the token input and leaves on the token output when done.
// - either accept bit, synchronous to the clock, captures and stores one event.
// - the sync bit clears and restarts the timer and trigger count in step with other boards.
// - busy is low normally and high when the event store nears full.
// - an overflow is latched as a fatal loss of event synchronisation.
// - the link payload of 32 bits per 4 ns is taken as two words per core cycle.
// - one event takes five write cycles so rates far above 200 kHz are kept.
// - the busy headroom covers every accept that can follow within 8 us.
// - every word returned from the event store is 32 bits wide.
`timescale 1ns/100ps
`include "terp_map.vh"

module terp_port #(
    parameter ADDR_W = 9,
    parameter [7:0] A32_BASE = 8'h08,
    parameter [7:0] A24_BASE = 8'h10
) (
    input wire i_core_clk,
    input wire i_reset_n,
    input wire i_accept_bit_a,
    input wire i_accept_bit_b,
    input wire i_sync,
    input wire [`TERP_LINK_W-1:0] i_fast_decision_link,
    input wire i_token_in,
    input wire i_bus_req,
    input wire i_bus_write,
    input wire [5:0] i_bus_am,
    input wire [31:0] i_bus_addr,
    input wire [31:0] i_bus_wdata,
    output reg o_bus_ack,
    output reg o_bus_err,
    output reg [31:0] o_bus_rdata,
    output reg o_token_out,
    output reg o_busy,
    output reg o_sync_lost
);
    localparam integer DEPTH = 1 << ADDR_W;
    localparam integer HEADROOM_I = `TERP_INFLIGHT_EV * `TERP_EV_WORDS;
    localparam integer THRESH_I = DEPTH - HEADROOM_I;
    // cut to pointer width on purpose; the headroom stays far below the depth
    localparam [ADDR_W:0] THRESH_RST = THRESH_I[ADDR_W:0];
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_HDR = 3'd1;
    localparam [2:0] S_TLO = 3'd2;
    localparam [2:0] S_THI = 3'd3;
    localparam [2:0] S_LK0 = 3'd4;
    localparam [2:0] S_LK1 = 3'd5;

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    function [1:0] terp_space;
        input [5:0] am;
        input [31:0] addr;
        input wr;
        begin
            terp_space = `TERP_SP_NONE;
            if ((am == `TERP_AM_A32_SGL || am == `TERP_AM_A32_BLT ||
                 am == `TERP_AM_A32_2ESST) && addr[31:24] == A32_BASE) begin
                terp_space = wr ? `TERP_SP_ERR : `TERP_SP_FIFO;
            end else if (am == `TERP_AM_A24_SGL && addr[23:16] == A24_BASE) begin
                terp_space = `TERP_SP_REG;
            end else if (am == `TERP_AM_A24_BLT && addr[23:16] == A24_BASE) begin
                terp_space = `TERP_SP_ERR;
            end
        end
    endfunction

    wire [1:0] space = terp_space(i_bus_am, i_bus_addr, i_bus_write);
    wire is_2esst = i_bus_am == `TERP_AM_A32_2ESST;

    reg [31:0] ctrl_reg;
    reg [ADDR_W:0] thresh_reg;
    reg [31:0] evcount_reg;
    reg [`TERP_TIMER_W-1:0] timer_reg;
    reg [`TERP_TRIGNUM_W-1:0] trignum_reg;
    reg [`TERP_TIMER_W-1:0] stamp_reg;
    reg [`TERP_LINK_W-1:0] link_reg;
    reg [7:0] pending_reg;
    reg [2:0] state_reg;
    reg [ADDR_W:0] wptr_reg;
    reg [ADDR_W:0] rptr_reg;
    reg token_held_reg;
    reg s1_valid_reg;
    reg [1:0] s1_kind_reg;
    reg [31:0] s1_data_reg;

    wire token_mode = ctrl_reg[`TERP_CTRL_TOKEN];
    wire [ADDR_W:0] count = wptr_reg - rptr_reg;
    wire empty = count == {(ADDR_W+1){1'b0}};
    wire full = count[ADDR_W];
    wire accept = (i_accept_bit_a | i_accept_bit_b) & ctrl_reg[`TERP_CTRL_CAPTURE];
    // a module without the grant stays silent on two-edge beats in token mode
    wire silent = is_2esst & token_mode & ~token_held_reg;
    wire take = i_bus_req & ~silent;
    wire fifo_rd = take & (space == `TERP_SP_FIFO) & ~empty;
    wire writing = state_reg != S_IDLE;
    wire wr_en = writing & ~full;
    reg [31:0] wr_word;
    wire [31:0] mem_q;

    // ------------------------------------------------------------------------
    // timestamp timer, cleared and restarted by sync
    // ------------------------------------------------------------------------
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            timer_reg <= {`TERP_TIMER_W{1'b0}};
        end else if (i_sync) begin
            timer_reg <= {`TERP_TIMER_W{1'b0}};
        end else begin
            timer_reg <= timer_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // event writer
    // ------------------------------------------------------------------------
    always @* begin
        case (state_reg)
            S_HDR: wr_word = {1'b1, `TERP_TYPE_EVHDR, trignum_reg};
            S_TLO: wr_word = {1'b1, `TERP_TYPE_TTIME, 3'b000, stamp_reg[`TERP_TIME_SPLIT-1:0]};
            S_THI: wr_word = {8'h00, stamp_reg[`TERP_TIMER_W-1:`TERP_TIME_SPLIT]};
            S_LK0: wr_word = link_reg[`TERP_WORD_W-1:0];
            S_LK1: wr_word = link_reg[`TERP_LINK_W-1:`TERP_WORD_W];
            default: wr_word = `TERP_FILLER;
        endcase
    end

    // accepts that land mid-event are queued and stamped when their turn comes
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= S_IDLE;
            pending_reg <= 8'h00;
            stamp_reg <= {`TERP_TIMER_W{1'b0}};
            link_reg <= {`TERP_LINK_W{1'b0}};
            trignum_reg <= {`TERP_TRIGNUM_W{1'b0}};
            evcount_reg <= 32'h0000_0000;
        end else begin
            if (i_sync) begin
                trignum_reg <= {`TERP_TRIGNUM_W{1'b0}};
            end
            case (state_reg)
                S_IDLE: begin
                    if (accept || pending_reg != 8'h00) begin
                        state_reg <= S_HDR;
                        stamp_reg <= timer_reg;
                        link_reg <= i_fast_decision_link;
                        if (!i_sync) begin
                            trignum_reg <= trignum_reg + 1'b1;
                        end
                        if (!accept) begin
                            pending_reg <= pending_reg - 1'b1;
                        end
                    end
                end
                S_HDR: state_reg <= S_TLO;
                S_TLO: state_reg <= S_THI;
                S_THI: state_reg <= S_LK0;
                S_LK0: state_reg <= S_LK1;
                S_LK1: begin
                    state_reg <= S_IDLE;
                    evcount_reg <= evcount_reg + 1'b1;
                end
                default: state_reg <= S_IDLE;
            endcase
            if (accept && writing && pending_reg != 8'hff) begin
                pending_reg <= pending_reg + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // event store pointers, busy and overflow
    // ------------------------------------------------------------------------
    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wptr_reg <= {(ADDR_W+1){1'b0}};
            rptr_reg <= {(ADDR_W+1){1'b0}};
            o_busy <= 1'b0;
            o_sync_lost <= 1'b0;
        end else begin
            if (wr_en) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (fifo_rd) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
            o_busy <= count >= thresh_reg;
            // sticky until reset: lost words cannot be recovered by software
            if (writing && full) begin
                o_sync_lost <= 1'b1;
            end
        end
    end

    terp_fifo_mem #(
        .WIDTH(`TERP_WORD_W),
        .ADDR_W(ADDR_W)
    ) u_mem (
        .i_core_clk(i_core_clk),
        .i_wr_en(wr_en),
        .i_wr_addr(wptr_reg[ADDR_W-1:0]),
        .i_wr_data(wr_word),
        .i_rd_en(fifo_rd),
        .i_rd_addr(rptr_reg[ADDR_W-1:0]),
        .o_rd_data(mem_q)
    );

    // ------------------------------------------------------------------------
    // bus slave: request, stage one, answer
    // ------------------------------------------------------------------------
    wire [7:0] roff = i_bus_addr[7:0];
    wire [31:0] status = {22'h0, token_held_reg, o_sync_lost, o_busy, empty, full,
        state_reg, writing, writing};

    always @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_reg <= `TERP_CTRL_RESET;
            thresh_reg <= THRESH_RST;
            s1_valid_reg <= 1'b0;
            s1_kind_reg <= `TERP_SP_NONE;
            s1_data_reg <= 32'h0000_0000;
            o_bus_ack <= 1'b0;
            o_bus_err <= 1'b0;
            o_bus_rdata <= 32'h0000_0000;
            token_held_reg <= 1'b0;
            o_token_out <= 1'b0;
        end else begin
            s1_valid_reg <= take;
            s1_kind_reg <= space;
            s1_data_reg <= `TERP_FILLER;
            if (take && space == `TERP_SP_FIFO && !empty) begin
                s1_data_reg <= 32'h0000_0000;
            end
            if (take && space == `TERP_SP_REG) begin
                case (roff)
                    `TERP_REG_CTRL: s1_data_reg <= ctrl_reg;
                    `TERP_REG_STATUS: s1_data_reg <= status;
                    `TERP_REG_THRESH: s1_data_reg <= {{(31-ADDR_W){1'b0}}, thresh_reg};
                    `TERP_REG_EVCOUNT: s1_data_reg <= evcount_reg;
                    default: s1_data_reg <= 32'h0000_0000;
                endcase
                if (i_bus_write && roff == `TERP_REG_CTRL) begin
                    ctrl_reg <= i_bus_wdata;
                end
                if (i_bus_write && roff == `TERP_REG_THRESH) begin
                    thresh_reg <= i_bus_wdata[ADDR_W:0];
                end
            end
            o_bus_ack <= s1_valid_reg & (s1_kind_reg == `TERP_SP_FIFO ||
                s1_kind_reg == `TERP_SP_REG);
            o_bus_err <= s1_valid_reg & (s1_kind_reg == `TERP_SP_ERR ||
                s1_kind_reg == `TERP_SP_NONE);
            // stage one holds zero for a live store word, so the or picks the memory
            o_bus_rdata <= (s1_kind_reg == `TERP_SP_FIFO) ? (s1_data_reg | mem_q) :
                s1_data_reg;
            if (s1_kind_reg == `TERP_SP_FIFO && s1_data_reg == `TERP_FILLER) begin
                o_bus_rdata <= `TERP_FILLER;
            end
            // token: held from its arrival until a two-edge beat finds the store empty
            o_token_out <= 1'b0;
            if (i_token_in) begin
                token_held_reg <= 1'b1;
            end else if (token_held_reg && i_bus_req && is_2esst && token_mode &&
                space == `TERP_SP_FIFO && empty) begin
                token_held_reg <= 1'b0;
                o_token_out <= 1'b1;
            end
        end
    end
endmodule // terp_port

/* terp_map.vh */
// constants shared by the trigger event readout port and its event store
// assumes a 125 MHz core clock; figures are named here, but the checker writes the address modifiers as literals
`ifndef TERP_MAP_VH
`define TERP_MAP_VH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define TERP_CLK_PERIOD_NS 8
`define TERP_TRIG_LATENCY_NS 8000
`define TERP_MIN_TRIG_PERIOD_NS 5000
`define TERP_LATENCY_CYC (`TERP_TRIG_LATENCY_NS / `TERP_CLK_PERIOD_NS)
// accepts that can still arrive after busy rises, rounded up
`define TERP_INFLIGHT_EV \
    ((`TERP_TRIG_LATENCY_NS + `TERP_MIN_TRIG_PERIOD_NS - 1) / `TERP_MIN_TRIG_PERIOD_NS)

// ----------------------------------------------------------------------------
// event layout
// ----------------------------------------------------------------------------
`define TERP_WORD_W 32
`define TERP_EV_WORDS 5
`define TERP_TIMER_W 48
`define TERP_TIME_SPLIT 24
`define TERP_TRIGNUM_W 27
`define TERP_LINK_W 64
`define TERP_TYPE_EVHDR 4'h2
`define TERP_TYPE_TTIME 4'h3
`define TERP_FILLER 32'hf800_0000

// ----------------------------------------------------------------------------
// bus address modifiers and decode
// ----------------------------------------------------------------------------
`define TERP_AM_A32_SGL 6'h09
`define TERP_AM_A32_BLT 6'h0b
`define TERP_AM_A32_2ESST 6'h20
`define TERP_AM_A24_SGL 6'h39
`define TERP_AM_A24_BLT 6'h3b
`define TERP_SP_NONE 2'h0
`define TERP_SP_FIFO 2'h1
`define TERP_SP_REG 2'h2
`define TERP_SP_ERR 2'h3

// ----------------------------------------------------------------------------
// 24-bit space registers (byte offsets within the board window)
// ----------------------------------------------------------------------------
`define TERP_REG_CTRL 8'h00
`define TERP_REG_STATUS 8'h04
`define TERP_REG_THRESH 8'h08
`define TERP_REG_EVCOUNT 8'h0c
`define TERP_CTRL_CAPTURE 0
`define TERP_CTRL_TOKEN 1
`define TERP_CTRL_RESET 32'h0000_0001

`endif

/* terp_fifo_mem.v */
// event store memory: one write port, one read port, registered read data
// assumes the caller keeps its own pointers and never reads and writes one slot blindly
`timescale 1ns/100ps

module terp_fifo_mem #(
    parameter WIDTH = 32,
    parameter ADDR_W = 9
) (
    input wire i_core_clk,
    input wire i_wr_en,
    input wire [ADDR_W-1:0] i_wr_addr,
    input wire [WIDTH-1:0] i_wr_data,
    input wire i_rd_en,
    input wire [ADDR_W-1:0] i_rd_addr,
    output reg [WIDTH-1:0] o_rd_data
);
    reg [WIDTH-1:0] mem_reg [0:(1<<ADDR_W)-1];

    // no reset on the array so it maps onto block memory
    always @(posedge i_core_clk) begin
        if (i_wr_en) begin
            mem_reg[i_wr_addr] <= i_wr_data;
        end
        if (i_rd_en) begin
            o_rd_data <= mem_reg[i_rd_addr];
        end
    end
endmodule // terp_fifo_mem

/* terp_port_sva.sv */
// assertion checker for the trigger event readout port
// sees only top-level ports; bound into every terp_port instance
`timescale 1ns/100ps

module terp_port_sva #(
    parameter [7:0] A32_BASE = 8'h08,
    parameter [7:0] A24_BASE = 8'h10
) (
    input wire i_core_clk,
    input wire i_reset_n,
    input wire i_bus_req,
    input wire i_bus_write,
    input wire [5:0] i_bus_am,
    input wire [31:0] i_bus_addr,
    input wire o_bus_ack,
    input wire o_bus_err,
    input wire o_token_out,
    input wire o_sync_lost
);
    // ------------------------------------------------------------------
    // bus decode, answer timing, token pulse and sync loss
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_a32;
        i_bus_req && i_bus_addr[31:24] == A32_BASE;
    endsequence
    sequence s_fifo_rd;
        s_a32 ##0 !i_bus_write && (i_bus_am == 6'h09 || i_bus_am == 6'h0b);
    endsequence
    sequence s_a24;
        i_bus_req && i_bus_addr[23:16] == A24_BASE;
    endsequence

    // a two-edge request may be ignored while the grant is elsewhere
    AST_BUS_ANSWER: assert property (i_bus_req && i_bus_am != 6'h20 |-> ##2 (o_bus_ack ^ o_bus_err))
        else $error("bus request not answered two cycles later");
    AST_NO_STRAY: assert property ((o_bus_ack || o_bus_err) |-> $past(i_bus_req, 2))
        else $error("bus answer without a request");
    AST_FIFO_RD: assert property (s_fifo_rd |-> ##2 o_bus_ack)
        else $error("event store read refused");
    AST_FIFO_WR: assert property (s_a32 ##0 i_bus_write && i_bus_am == 6'h09 |-> ##2 o_bus_err)
        else $error("event store write accepted");
    AST_REG_SGL: assert property (s_a24 ##0 i_bus_am == 6'h39 |-> ##2 o_bus_ack)
        else $error("register single access refused");
    AST_REG_BLT: assert property (i_bus_req && i_bus_am == 6'h3b |-> ##2 o_bus_err)
        else $error("register block access accepted");
    AST_TOKEN_PULSE: assert property (o_token_out |=> !o_token_out)
        else $error("token output longer than one cycle");
    // the pass comes out with stage one, the answer to that beat one cycle later
    AST_TOKEN_CAUSE: assert property (o_token_out |=> o_bus_ack)
        else $error("token passed without a readout beat");
    AST_SYNC_STICKY: assert property (o_sync_lost |=> o_sync_lost)
        else $error("sync loss flag cleared");
endmodule // terp_port_sva

bind terp_port terp_port_sva #(.A32_BASE(A32_BASE), .A24_BASE(A24_BASE)) u_sva (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_bus_req(i_bus_req),
    .i_bus_write(i_bus_write),
    .i_bus_am(i_bus_am),
    .i_bus_addr(i_bus_addr),
    .o_bus_ack(o_bus_ack),
    .o_bus_err(o_bus_err),
    .o_token_out(o_token_out),
    .o_sync_lost(o_sync_lost)
);

/* terp_super_model.sv */
// trigger supervisor model: accept bits and sync toward the port
// bench gives single shots; run mode paces one accept every six cycles
`timescale 1ns/100ps

module terp_super_model (
    input wire i_core_clk,
    input wire i_busy,
    input wire [1:0] i_mode,
    input wire [2:0] i_shot,
    output reg o_accept_bit_a = 1'b0,
    output reg o_accept_bit_b = 1'b0,
    output reg o_sync = 1'b0
);
    reg [2:0] gap_reg = 3'h0;
    wire run_ok;

    // -------------------------------------------------------------
    // pacing
    // -------------------------------------------------------------
    // mode 2 ignores busy on purpose, only to provoke an overflow
    assign run_ok = i_mode == 2'h2 || (i_mode == 2'h1 && !i_busy);
    always @(negedge i_core_clk) begin
        gap_reg <= (gap_reg == 3'h5) ? 3'h0 : gap_reg + 3'h1;
        o_accept_bit_a <= i_shot[0] | (gap_reg == 3'h0 && run_ok);
        o_accept_bit_b <= i_shot[1];
        o_sync <= i_shot[2];
    end
endmodule // terp_super_model

/* terp_port_test.sv */
// self-checking bench for the trigger event readout port
// assumes the supervisor model drives accepts and sync; bench drives the bus
`timescale 1ns/100ps
`include "terp_map.vh"

module terp_port_test;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg token_in = 1'b0;
    reg req = 1'b0;
    reg wr = 1'b0;
    reg [5:0] am = 6'h00;
    reg [31:0] addr = 32'h0;
    reg [31:0] wdata = 32'h0;
    reg [1:0] mode = 2'h0;
    reg [2:0] shot = 3'h0;
    reg [63:0] link = 64'h0123_4567_89ab_cdef;
    reg [1:0] r;
    reg [31:0] q;
    wire acc_a, acc_b, sync, ack, err, tok_out, busy, lost;
    wire [31:0] rdata;
    integer num_errors = 0;
    integer checked = 0;
    integer tok_seen = 0;
    integer i;
    localparam [31:0] RB = 32'h0010_0000;
    localparam [31:0] FB = 32'h0800_0000;

    always #4 clk = ~clk;
    always @(posedge clk) if (tok_out === 1'b1) tok_seen = tok_seen + 1;

    terp_port u_terp_port (.i_core_clk(clk), .i_reset_n(rst_n), .i_accept_bit_a(acc_a),
        .i_accept_bit_b(acc_b), .i_sync(sync), .i_fast_decision_link(link),
        .i_token_in(token_in), .i_bus_req(req), .i_bus_write(wr), .i_bus_am(am),
        .i_bus_addr(addr), .i_bus_wdata(wdata), .o_bus_ack(ack), .o_bus_err(err),
        .o_bus_rdata(rdata), .o_token_out(tok_out), .o_busy(busy), .o_sync_lost(lost));
    terp_super_model u_terp_super_model (.i_core_clk(clk), .i_busy(busy), .i_mode(mode),
        .i_shot(shot), .o_accept_bit_a(acc_a), .o_accept_bit_b(acc_b), .o_sync(sync));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task check(input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    // one-cycle strobe; r is {ack, err}, zero when nothing answers
    task bus(input [5:0] m, input [31:0] a, input w, input [31:0] d);
        integer n;
        begin
            @(negedge clk);
            req = 1'b1;
            am = m;
            addr = a;
            wr = w;
            wdata = d;
            @(negedge clk);
            req = 1'b0;
            r = 2'h0;
            for (n = 0; n < 4 && r == 2'h0; n = n + 1) begin
                @(posedge clk);
                #1;
                r = {ack, err};
            end
            q = rdata;
        end
    endtask

    task fire(input [2:0] s);
        begin
            @(negedge clk);
            shot <= s;
            @(negedge clk);
            shot <= 3'h0;
        end
    endtask

    task end_sim;
        begin
            $display("checks %0d mismatches %0d", checked, num_errors);
            if (num_errors == 0 && checked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_regs;
        begin
            bus(6'h39, RB, 1'b0, 32'h0);
            check(q, 32'h1);
            bus(6'h39, RB + 32'h8, 1'b0, 32'h0);
            check(q, 32'h1f6);
            bus(6'h3b, RB, 1'b0, 32'h0);
            check(r, 2'h1);
            bus(6'h09, FB, 1'b1, 32'h5);
            check(r, 2'h1);
            bus(6'h09, 32'h0900_0000, 1'b0, 32'h0);
            check(r, 2'h1);
            $display("test regs done");
        end
    endtask

    // second accept lands while the first event is still being written
    task t_event;
        begin
            fire(3'h1);
            fire(3'h2);
            repeat (14) @(negedge clk);
            for (i = 0; i < 2; i = i + 1) begin
                bus(6'h09, FB, 1'b0, 32'h0);
                check(q, 32'h9000_0001 + i);
                bus(6'h0b, FB, 1'b0, 32'h0);
                check(q[31:24], 8'h98);
                bus(6'h0b, FB, 1'b0, 32'h0);
                check(q[31:24], 8'h00);
                bus(6'h09, FB, 1'b0, 32'h0);
                check(q, link[31:0]);
                bus(6'h0b, FB, 1'b0, 32'h0);
                check(q, link[63:32]);
            end
            bus(6'h09, FB, 1'b0, 32'h0);
            check({30'h0, r}, 32'h2);
            check(q, `TERP_FILLER);
            fire(3'h4);
            fire(3'h1);
            repeat (8) @(negedge clk);
            bus(6'h09, FB, 1'b0, 32'h0);
            check(q, 32'h9000_0001);
            bus(6'h09, FB, 1'b0, 32'h0);
            check(q & 32'hffff_fff0, 32'h9800_0000);
            repeat (3) bus(6'h09, FB, 1'b0, 32'h0);
            $display("test event done");
        end
    endtask

    task t_token;
        begin
            bus(6'h39, RB + 32'hc, 1'b0, 32'h0);
            check(q, 32'h3);
            bus(6'h39, RB + 32'h4, 1'b0, 32'h0);
            check(q, 32'h40);
            bus(6'h39, RB, 1'b1, 32'h3);
            bus(6'h20, FB, 1'b0, 32'h0);
            check(r, 2'h0);
            @(negedge clk);
            token_in = 1'b1;
            @(negedge clk);
            token_in = 1'b0;
            bus(6'h20, FB, 1'b0, 32'h0);
            check(r, 2'h2);
            repeat (3) @(negedge clk);
            check(tok_seen, 1);
            bus(6'h39, RB, 1'b1, 32'h1);
            $display("test token done");
        end
    endtask

    task t_busy;
        begin
            check(busy, 1'b0);
            mode = 2'h1;
            for (i = 0; i < 1000 && busy !== 1'b1; i = i + 1) @(negedge clk);
            check(busy, 1'b1);
            repeat (200) @(negedge clk);
            check(lost, 1'b0);
            mode = 2'h2;
            for (i = 0; i < 200 && lost !== 1'b1; i = i + 1) @(negedge clk);
            mode = 2'h0;
            check(lost, 1'b1);
            $display("test busy done");
        end
    endtask

    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_regs;
        t_event;
        t_token;
        t_busy;
        end_sim;
    end

    // whole run needs about 1000 cycles
    initial begin
        #400000;
        num_errors = num_errors + 1;
        end_sim;
    end
endmodule // terp_port_test
